/* File: core/bb_cfg_consts.svh */
`ifndef BB_CFG_CONSTS_SVH
`define BB_CFG_CONSTS_SVH

`define ADDR_ACQ_CFG        5'h10
`define ADDR_TRACK_CFG      5'h11
`define ADDR_LOSS_CFG       5'h12
`define ADDR_PATTERN_BYTE0  5'h13
`define ADDR_PATTERN_BYTE1  5'h14
`define ADDR_PATTERN_BYTE2  5'h15
`define ADDR_PATTERN_BYTE3  5'h16
`define ADDR_TEST_FILTER    5'h17
`define ADDR_BANK_BASE      5'h10
`define BANK_SIZE           8
`define IDX_ACQ_CFG         3'h0
`define IDX_TRACK_CFG       3'h1
`define IDX_LOSS_CFG        3'h2
`define IDX_PATTERN_BYTE0   3'h3
`define IDX_TEST_FILTER     3'h7
`define CFG_RESET_VALUE     8'h00
`define BIT_PROGRAM_ENABLE  7
`define BIT_SPLIT_DATA      7
`define BIT_ROBUST_BITSYNC  7
`define BIT_WIDTH_OVERRIDE  3
`define FIELD_THRESH_MSB    6
`define FIELD_HPF_MSB       1
`define FIXED_ACQ_THRESH    7'h00
`define FIXED_TRACK_THRESH  7'h00
`define FIXED_LOSS_BITS     7'h32
`define PATTERN_BITS        32

`endif

/* File: core/bb_cfg_pkg.sv */
package bb_cfg_pkg;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_RECEIVE,
    MODE_TRANSMIT
  } op_mode_e;

  typedef struct packed {
    logic osc_en;
    logic synth_en;
    logic rx_en;
    logic tx_en;
  } power_enables_s;

  typedef struct packed {
    logic [6:0] acquisition_threshold;
    logic [6:0] tracking_threshold;
    logic [6:0] sync_loss_bit_count;
  } barker_params_s;

  typedef struct packed {
    logic       filter_width_override;
    logic [1:0] highpass_corner_select;
    logic       robust_bitsync_select;
  } analog_opts_s;

endpackage : bb_cfg_pkg

/* File: core/pattern_matcher.sv */
`timescale 1ns/1ns
`include "bb_cfg_consts.svh"

module pattern_matcher
  import bb_cfg_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        bit_valid_in,
  input  wire logic        bit_in,
  input  wire logic [1:0]  length_sel_in,
  input  wire logic [31:0] pattern_in,
  output logic             match_out
);

  // mask of the newest 8, 16, 24 or 32 received bits
  function automatic logic [31:0] len_mask(input logic [1:0] sel);
    logic [31:0] m;
    case (sel)
      2'b00:   m = 32'h0000_00ff;
      2'b01:   m = 32'h0000_ffff;
      2'b10:   m = 32'h00ff_ffff;
      default: m = 32'hffff_ffff;
    endcase
    return m;
  endfunction : len_mask

  logic [31:0] window_reg;
  logic [31:0] window_next;
  logic        match_reg;
  logic        match_next;
  logic [31:0] mask;
  logic [31:0] ref_aligned;

  // byte0 is the msb; shifting right drops unused trailing bytes
  assign mask        = len_mask(length_sel_in);
  assign ref_aligned = pattern_in >> {~length_sel_in, 3'b000};
  // newest bit enters at bit 0, earliest ends up at the top
  assign window_next = bit_valid_in ? {window_reg[30:0], bit_in} : window_reg;
  // compare only when a fresh bit arrives, so a stale window never rematches
  assign match_next  = bit_valid_in && ((window_next & mask) == (ref_aligned & mask));

  // window and match flag
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      window_reg <= 32'h0000_0000;
      match_reg  <= 1'b0;
    end else begin
      window_reg <= window_next;
      match_reg  <= match_next;
    end
  end

  assign match_out = match_reg;

endmodule : pattern_matcher

/* File: core/baseband_config_and_pattern_match.sv */
`timescale 1ns/1ns
`include "bb_cfg_consts.svh"

module baseband_config_and_pattern_match
  import bb_cfg_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // register port from the serial interface shifter
  input  wire logic        wr_en_in,
  input  wire logic [4:0]  wr_addr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic [4:0]  rd_addr_in,
  output logic [7:0]       rd_data_out,
  input  wire logic        if_enable_n_in,
  // loose configuration bits held elsewhere
  input  wire logic [1:0]  pattern_length_select_in,
  input  wire logic        config_set2_select_in,
  input  wire logic [1:0]  set1_operating_mode_in,
  input  wire logic [1:0]  set2_operating_mode_in,
  // demodulator bits
  input  wire logic        rx_bit_valid_in,
  input  wire logic        rx_bit_in,
  // data pins
  input  wire logic        data_pin_in,
  output logic             data_pin_out,
  output logic             data_pin_oe_n_out,
  input  wire logic        tx_input_pin_in,
  output logic             tx_data_out,
  // applied configuration
  output barker_params_s   barker_params_out,
  output analog_opts_s     analog_opts_out,
  output power_enables_s   power_enables_out,
  output logic             pattern_match_out
);

  // three-stage synchroniser for an asynchronous pin, filtered on agreement
  logic [2:0] en_sync_reg;
  logic [2:0] din_sync_reg;
  logic [2:0] txin_sync_reg;
  logic       en_stable_reg;
  logic       din_stable_reg;
  logic       txin_stable_reg;
  logic       en_stable_next;
  logic       din_stable_next;
  logic       txin_stable_next;

  // a new level counts only once the second and third stages agree
  function automatic logic settle(input logic [2:0] sync, input logic held);
    return (sync[1] == sync[2]) ? sync[2] : held;
  endfunction : settle

  assign en_stable_next   = settle(en_sync_reg, en_stable_reg);
  assign din_stable_next  = settle(din_sync_reg, din_stable_reg);
  assign txin_stable_next = settle(txin_sync_reg, txin_stable_reg);

  // idle enable is high, so it resets high to avoid a false apply edge
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_sync_reg     <= 3'b111;
      din_sync_reg    <= 3'b000;
      txin_sync_reg   <= 3'b000;
      en_stable_reg   <= 1'b1;
      din_stable_reg  <= 1'b0;
      txin_stable_reg <= 1'b0;
    end else begin
      en_sync_reg     <= {en_sync_reg[1:0], if_enable_n_in};
      din_sync_reg    <= {din_sync_reg[1:0], data_pin_in};
      txin_sync_reg   <= {txin_sync_reg[1:0], tx_input_pin_in};
      en_stable_reg   <= en_stable_next;
      din_stable_reg  <= din_stable_next;
      txin_stable_reg <= txin_stable_next;
    end
  end

  // bank hit: upper address bits pick the eight-byte block
  function automatic logic in_bank(input logic [4:0] addr);
    logic [4:0] base;
    base = `ADDR_BANK_BASE;
    return addr[4:3] == base[4:3];
  endfunction : in_bank

  // address decode of the eight-byte bank
  logic       wr_hit;
  logic       rd_hit;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic       apply_edge;

  assign wr_hit     = wr_en_in && in_bank(wr_addr_in);
  assign rd_hit     = in_bank(rd_addr_in);
  assign wr_idx     = wr_addr_in[2:0];
  assign rd_idx     = rd_addr_in[2:0];
  assign apply_edge = !en_stable_reg && en_stable_next;

  // shadow holds host writes; active copy changes only on enable release
  logic [7:0] shadow_reg [`BANK_SIZE];
  logic [7:0] active_reg [`BANK_SIZE];

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `BANK_SIZE; i++) begin
        shadow_reg[i] <= `CFG_RESET_VALUE;
        active_reg[i] <= `CFG_RESET_VALUE;
      end
    end else begin
      if (wr_hit) begin
        shadow_reg[wr_idx] <= wr_data_in;
      end
      if (apply_edge) begin
        for (int i = 0; i < `BANK_SIZE; i++) begin
          active_reg[i] <= shadow_reg[i];
        end
      end
    end
  end

  // readback returns what the host wrote; unmapped addresses read zero
  logic [7:0] rd_data_next;
  assign rd_data_next = rd_hit ? shadow_reg[rd_idx] : 8'h00;

  // threshold selection
  logic           prog_en;
  barker_params_s barker_next;
  assign prog_en = active_reg[`IDX_ACQ_CFG][`BIT_PROGRAM_ENABLE];
  assign barker_next.acquisition_threshold = prog_en ?
           active_reg[`IDX_ACQ_CFG][`FIELD_THRESH_MSB:0] : `FIXED_ACQ_THRESH;
  assign barker_next.tracking_threshold = prog_en ?
           active_reg[`IDX_TRACK_CFG][`FIELD_THRESH_MSB:0] : `FIXED_TRACK_THRESH;
  assign barker_next.sync_loss_bit_count = prog_en ?
           active_reg[`IDX_LOSS_CFG][`FIELD_THRESH_MSB:0] : `FIXED_LOSS_BITS;

  // filter and bit synchroniser options
  analog_opts_s opts_next;
  assign opts_next.filter_width_override  =
           active_reg[`IDX_TEST_FILTER][`BIT_WIDTH_OVERRIDE];
  assign opts_next.highpass_corner_select =
           active_reg[`IDX_TEST_FILTER][`FIELD_HPF_MSB:0];
  assign opts_next.robust_bitsync_select  =
           active_reg[`IDX_LOSS_CFG][`BIT_ROBUST_BITSYNC];

  // operating mode decode
  op_mode_e       mode;
  power_enables_s power_next;
  assign mode = op_mode_e'(config_set2_select_in ? set2_operating_mode_in
                                                 : set1_operating_mode_in);
  assign power_next.osc_en   = (mode != MODE_SLEEP);
  assign power_next.synth_en = (mode == MODE_RECEIVE) || (mode == MODE_TRANSMIT);
  assign power_next.rx_en    = (mode == MODE_RECEIVE);
  assign power_next.tx_en    = (mode == MODE_TRANSMIT);

  // data pin direction: bidirectional pin is input only while transmitting with split data clear
  logic split_data;
  logic pin_oe_n_next;
  logic tx_data_next;
  assign split_data    = active_reg[`IDX_TRACK_CFG][`BIT_SPLIT_DATA];
  assign pin_oe_n_next = !split_data && (mode == MODE_TRANSMIT);
  assign tx_data_next  = split_data ? txin_stable_reg : din_stable_reg;

  // reference pattern, byte at 0x13 first
  logic [31:0] pattern_word;
  assign pattern_word = {active_reg[`IDX_PATTERN_BYTE0], active_reg[`IDX_PATTERN_BYTE0 + 3'd1],
                         active_reg[`IDX_PATTERN_BYTE0 + 3'd2],
                         active_reg[`IDX_PATTERN_BYTE0 + 3'd3]};

  logic match;
  pattern_matcher u_matcher (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .bit_valid_in  (rx_bit_valid_in),
    .bit_in        (rx_bit_in),
    .length_sel_in (pattern_length_select_in),
    .pattern_in    (pattern_word),
    .match_out     (match)
  );

  // output registers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out       <= 8'h00;
      barker_params_out <= '0;
      analog_opts_out   <= '0;
      power_enables_out <= '0;
      data_pin_out      <= 1'b0;
      data_pin_oe_n_out <= 1'b1;
      tx_data_out       <= 1'b0;
      pattern_match_out <= 1'b0;
    end else begin
      rd_data_out       <= rd_data_next;
      barker_params_out <= barker_next;
      analog_opts_out   <= opts_next;
      power_enables_out <= power_next;
      data_pin_out      <= rx_bit_in;
      data_pin_oe_n_out <= pin_oe_n_next;
      tx_data_out       <= tx_data_next;
      pattern_match_out <= match;
    end
  end

endmodule : baseband_config_and_pattern_match

/* File: verification/host_model.sv */
`timescale 1ns/1ns
module host_model (
  input  wire logic       ref_clk_in,
  output logic            wr_en_out,
  output logic [4:0]      wr_addr_out,
  output logic [7:0]      wr_data_out,
  output logic            if_enable_n_out
);
  // idle interface: enable high, no strobe
  initial begin
    wr_en_out       = 1'b0;
    wr_addr_out     = 5'h00;
    wr_data_out     = 8'h00;
    if_enable_n_out = 1'b1;
  end
  // one write inside a programming sequence
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    if_enable_n_out = 1'b0;
    wr_en_out       = 1'b1;
    wr_addr_out     = a;
    wr_data_out     = d;
    @(negedge ref_clk_in);
    wr_en_out       = 1'b0;
    wr_data_out     = ~d; // released data bus shows no stale value
  endtask : wr
  // enable held low long enough for the pin synchroniser, then raised
  task automatic apply();
    repeat (4) @(negedge ref_clk_in);
    if_enable_n_out = 1'b1;
    repeat (8) @(negedge ref_clk_in);
  endtask : apply
endmodule : host_model

/* File: verification/baseband_config_and_pattern_match_asserts.sv */
`timescale 1ns/1ns
module baseband_config_and_pattern_match_asserts
  import bb_cfg_pkg::*;
(
  input wire logic           ref_clk_in,
  input wire logic           rst_n_in,
  input wire logic [4:0]     rd_addr_in,
  input wire logic [7:0]     rd_data_out,
  input wire logic           if_enable_n_in,
  input wire logic           config_set2_select_in,
  input wire logic [1:0]     set1_operating_mode_in,
  input wire logic [1:0]     set2_operating_mode_in,
  input wire logic           rx_bit_valid_in,
  input wire logic           rx_bit_in,
  input wire logic           data_pin_out,
  input wire logic           data_pin_oe_n_out,
  input wire barker_params_s barker_params_out,
  input wire power_enables_s power_enables_out,
  input wire logic           pattern_match_out
);
  logic [1:0] mode_sel;
  logic [3:0] quiet_reg;
  logic       up_reg;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // mode field of whichever set is active
  assign mode_sel = config_set2_select_in ? set2_operating_mode_in : set1_operating_mode_in;
  // edges with enable idle, saturating; $past is unsafe on the first edge out of reset
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_reg <= 4'h0;
      up_reg    <= 1'b0;
    end else begin
      quiet_reg <= !if_enable_n_in ? 4'h0 : (quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1;
      up_reg    <= 1'b1;
    end
  end
  sequence s_quiet;
    quiet_reg >= 4'h9;
  endsequence
  a_cfg_hold:
    assert property (s_quiet |-> $stable(barker_params_out)) else $error("config moved");
  a_rd_unmapped:
    assert property ((rd_addr_in < 5'h10) || (rd_addr_in > 5'h17) |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_pwr_sleep:
    assert property (mode_sel == 2'h0 |=> power_enables_out == 4'h0) else $error("sleep");
  a_pwr_standby:
    assert property (mode_sel == 2'h1 |=> power_enables_out == 4'h8) else $error("standby");
  a_pwr_receive:
    assert property (mode_sel == 2'h2 |=> power_enables_out == 4'he) else $error("receive");
  a_pwr_transmit:
    assert property (mode_sel == 2'h3 |=> power_enables_out == 4'hd) else $error("transmit");
  a_oe_transmit_only:
    assert property (up_reg && data_pin_oe_n_out |-> $past(mode_sel) == 2'h3)
    else $error("pin released outside transmit");
  a_pin_follows_bit:
    assert property (1'b1 |=> data_pin_out == $past(rx_bit_in)) else $error("data pin lag");
  a_match_after_bit:
    assert property (pattern_match_out |-> $past(rx_bit_valid_in, 2)) else $error("stray match");
endmodule : baseband_config_and_pattern_match_asserts
bind baseband_config_and_pattern_match baseband_config_and_pattern_match_asserts chk (
  .ref_clk_in, .rst_n_in, .rd_addr_in, .rd_data_out, .if_enable_n_in, .config_set2_select_in,
  .set1_operating_mode_in, .set2_operating_mode_in, .rx_bit_valid_in, .rx_bit_in,
  .data_pin_out, .data_pin_oe_n_out, .barker_params_out, .power_enables_out,
  .pattern_match_out);

/* File: verification/baseband_config_and_pattern_match_tb.sv */
`timescale 1ns/1ns
module baseband_config_and_pattern_match_tb;
  import bb_cfg_pkg::*;
  logic           clk, rst_n, wr_en, en_n, set2, rxv, rxb, pin, txin, pin_out, oe_n, txd, match;
  logic [4:0]     wr_addr, rd_addr;
  logic [7:0]     wr_data, rd_data;
  logic [1:0]     plen, mode1, mode2;
  barker_params_s bp;
  analog_opts_s   ao;
  power_enables_s pe;
  int             error_cnt, num_checks;
  logic [31:0]    pat;
  localparam logic [3:0] pwr_tab [4] = '{4'h0, 4'h8, 4'he, 4'hd};

  host_model host (.ref_clk_in(clk), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data), .if_enable_n_out(en_n));
  baseband_config_and_pattern_match DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .wr_en_in(wr_en),
    .wr_addr_in(wr_addr), .wr_data_in(wr_data), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
    .if_enable_n_in(en_n), .pattern_length_select_in(plen), .config_set2_select_in(set2),
    .set1_operating_mode_in(mode1), .set2_operating_mode_in(mode2), .rx_bit_valid_in(rxv),
    .rx_bit_in(rxb), .data_pin_in(pin), .data_pin_out(pin_out), .data_pin_oe_n_out(oe_n),
    .tx_input_pin_in(txin), .tx_data_out(txd), .barker_params_out(bp),
    .analog_opts_out(ao), .power_enables_out(pe), .pattern_match_out(match));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // readback answers one edge after the address is taken
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    chk(rd_data, exp);
  endtask : rd
  // bits go out oldest first, one strobe per cycle; match must land two edges later
  task automatic send(input logic [31:0] w, input int n, input logic exp);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk);
      rxv = 1'b1;
      rxb = w[i];
    end
    @(negedge clk);
    rxv = 1'b0;
    @(negedge clk);
    chk(match, exp);
    @(negedge clk);
    chk(match, 1'b0); // one-cycle pulse
  endtask : send
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {rst_n, set2, rxv, rxb, pin, txin, plen, mode1, mode2, rd_addr} = '0;
    error_cnt = 0;
    num_checks = 0;
    pat = 32'h93aa_9b5a;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(bp, {7'h00, 7'h00, 7'h32});
    chk(ao, 4'h0);
    for (int a = 16; a < 24; a++) rd(a[4:0], 8'h00);
    $display("reset test done");
    host.wr(5'h10, 8'h85);
    host.wr(5'h11, 8'h0c);
    host.wr(5'h12, 8'ha7);
    for (int i = 0; i < 4; i++) host.wr(5'h13 + i[4:0], pat[31 - 8 * i -: 8]);
    host.wr(5'h17, 8'h0a);
    host.wr(5'h08, 8'hff);
    rd(5'h13, 8'h93);
    rd(5'h16, 8'h5a);
    rd(5'h08, 8'h00);
    chk(bp, {7'h00, 7'h00, 7'h32});
    host.apply();
    chk(bp, {7'h05, 7'h0c, 7'h27});
    chk(ao, {1'b1, 2'h2, 1'b1});
    for (int h = 0; h < 4; h++) begin
      host.wr(5'h17, {6'h00, h[1:0]});
      host.apply();
      chk(ao, {1'b0, h[1:0], 1'b1});
    end
    host.wr(5'h10, 8'h05);
    host.apply();
    chk(bp, {7'h00, 7'h00, 7'h32});
    $display("register test done");
    for (int m = 0; m < 8; m++) begin
      @(negedge clk);
      set2 = m[2];
      mode1 = m[2] ? ~m[1:0] : m[1:0];
      mode2 = m[2] ? m[1:0] : ~m[1:0];
      @(negedge clk);
      chk(pe, pwr_tab[m[1:0]]);
      chk(oe_n, m[1:0] == 2'h3);
    end
    $display("mode test done");
    txin = 1'b1;
    host.wr(5'h11, 8'h80);
    host.apply();
    chk(txd, 1'b1);
    chk(oe_n, 1'b0);
    txin = 1'b0;
    pin  = 1'b1;
    host.wr(5'h11, 8'h00);
    host.apply();
    chk(txd, 1'b1);
    chk(oe_n, 1'b1);
    $display("pin test done");
    mode2 = 2'h2;
    for (int l = 0; l < 4; l++) begin
      plen = l[1:0];
      send(pat >> (24 - 8 * l), 8 * l + 8, 1'b1);
      send((pat >> (24 - 8 * l)) ^ 32'h0000_0001, 8 * l + 8, 1'b0);
    end
    $display("pattern test done");
    give_verdict();
  end
endmodule : baseband_config_and_pattern_match_tb
